/* dv/high_side_switches.sv */
module high_side_switches (
    // clock
    input wire logic clk_i,
    // switch commands and test load faults
    input wire logic [3:0] drive_i,
    input wire logic [3:0] overload_i,
    // fault flags
    output logic [3:0] fault_o = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // a shorted load only trips while its switch conducts
    always @(posedge clk_i)
    begin
        fault_o <= drive_i & overload_i;
    end
endmodule

/* dv/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import switch_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic srst = 1'b0, rmode = 1'b0, ov = 1'b0, uv = 1'b0;
    logic [8:0] adr = 9'h0;
    logic [3:0] sel = 4'h0, sel_req = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [3:0] fault, drive, overload = 4'h0;
    int fail_count = 0, samples_checked = 0;
    logic [8:0] regs [4] = '{9'h34, 9'h40, 9'h50, 9'h54};
    logic [7:0] rmask [4] = '{8'h77, 8'h70, 8'h77, 8'h77};
    logic [20:0] steps [13] = '{
        {9'h50, 8'h10, 4'h2}, {9'h54, 8'h01, 4'h6}, {9'h54, 8'h10, 4'ha},
        {9'h34, 8'h60, 4'ha}, {9'h50, 8'h33, 4'hb}, {9'h34, 8'h00, 4'h8},
        {9'h34, 8'h70, 4'h8}, {9'h50, 8'h66, 4'h8}, {9'h50, 8'h22, 4'h8},
        {9'h30, 8'h60, 4'hb}, {9'h50, 8'h45, 4'h8}, {9'h60, 8'hff, 4'ha},
        {9'h64, 8'hff, 4'hb}};

    always #2.5 clk_i = ~clk_i;

    switch_timer_ctrl #(.TICK_LEN(20)) u_switch_timer_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .soft_reset_i(srst), .restart_mode_i(rmode), .supply_ov_i(ov), .supply_uv_i(uv),
        .switch_fault_i(fault), .switch_drive_o(drive));

    high_side_switches u_high_side_switches (
        .clk_i(clk_i), .drive_i(drive), .overload_i(overload), .fault_o(fault));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_req;
        adr <= a;
        wdat <= {24'h0, d};
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            if (ack === 1'b1)
                break;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (n >= 20)
        begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h0);
        chk("register", {24'h0, e}, rd);
    endtask

    task automatic dchk(input logic [3:0] e);
        chk("drive", {28'h0, e}, {28'h0, drive});
    endtask

    initial
    begin
        waitc(20000);
        fail_count++;
        summarize();
    end

    initial
    begin
        waitc(16);
        rst_i <= 1'b0;
        foreach (regs[i]) rdchk(regs[i], 8'h00);
        foreach (regs[i])
        begin
            wb(1'b1, regs[i], 8'hff);
            rdchk(regs[i], rmask[i]);
        end
        waitc(3);
        dchk(4'h0);
        wb(1'b1, 9'h1fc, 8'hff);
        rdchk(9'h1fc, 8'h00);
        $display("test registers done");
        foreach (steps[i])
        begin
            wb(1'b1, steps[i][20:12], steps[i][11:4]);
            waitc(3);
            dchk(steps[i][3:0]);
        end
        $display("test selection done");
        wb(1'b1, 9'h50, 8'h11);
        wb(1'b1, 9'h54, 8'h11);
        wb(1'b1, 9'h40, 8'h00);
        ov <= 1'b1;
        waitc(6);
        dchk(4'h0);
        ov <= 1'b0;
        waitc(6);
        rdchk(9'h50, 8'h00);
        wb(1'b1, 9'h50, 8'h11);
        wb(1'b1, 9'h54, 8'h11);
        wb(1'b1, 9'h40, 8'h10);
        uv <= 1'b1;
        waitc(6);
        dchk(4'h0);
        uv <= 1'b0;
        waitc(6);
        dchk(4'hf);
        wb(1'b1, 9'h40, 8'h60);
        ov <= 1'b1;
        uv <= 1'b1;
        waitc(6);
        dchk(4'hf);
        ov <= 1'b0;
        uv <= 1'b0;
        overload <= 4'h4;
        waitc(8);
        rdchk(9'h54, 8'h10);
        overload <= 4'h0;
        $display("test faults done");
        wb(1'b1, 9'h34, 8'h21);
        rmode <= 1'b1;
        waitc(2);
        rmode <= 1'b0;
        foreach (regs[i]) rdchk(regs[i], (i == 1) ? 8'h60 : 8'h00);
        rdchk(9'h30, 8'h00);
        wb(1'b1, 9'h50, 8'h11);
        srst <= 1'b1;
        waitc(2);
        srst <= 1'b0;
        rdchk(9'h50, 8'h00);
        sel_req = 4'h0;
        wb(1'b1, 9'h50, 8'h11);
        sel_req = 4'h1;
        rdchk(9'h50, 8'h00);
        $display("test clearing done");
        wb(1'b1, 9'h50, 8'h03);
        wb(1'b1, 9'h34, 8'h20);
        waitc(8);
        dchk(4'h1);
        waitc(82);
        dchk(4'h0);
        waitc(1928);
        dchk(4'h1);
        $display("test timer done");
        summarize();
    end
endmodule

/* rtl/interval_gen.sv */
module interval_gen
    import switch_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // tick and setup
    input wire logic tick_i,
    input wire logic [2:0] on_code_i,
    input wire logic [2:0] per_code_i,
    // pulse
    output logic pulse_o
);

    logic [14:0] cnt_reg, cnt_next;
    logic [2:0] on_prev_reg;
    logic [2:0] per_prev_reg;
    logic pulse_reg, pulse_next;
    logic [14:0] on_len;
    logic [14:0] per_len;
    logic running;
    logic changed;

    always_comb
    begin
        on_len = on_ticks(on_code_i);
        per_len = per_ticks(per_code_i);
        // runs as soon as a pulse width is set and the interval code is not reserved
        running = (on_len != 15'h0) && (per_code_i != PER_RSVD);
        changed = (on_code_i != on_prev_reg) || (per_code_i != per_prev_reg);
        cnt_next = cnt_reg;
        if (changed || !running)
        begin
            cnt_next = 15'h0;
        end
        else if (tick_i)
        begin
            cnt_next = (cnt_reg >= per_len - 15'd1) ? 15'h0 : cnt_reg + 15'd1;
        end
        // on-time window, held high, reserved low
        if (on_code_i == ON_OFF_HIGH)
        begin
            pulse_next = 1'b1;
        end
        else
        begin
            pulse_next = running && (cnt_next < on_len);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 15'h0;
            on_prev_reg <= RESET_CODE;
            per_prev_reg <= RESET_CODE;
            pulse_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            on_prev_reg <= on_code_i;
            per_prev_reg <= per_code_i;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse_o = pulse_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_off_low_hold: assert property ((on_code_i == ON_OFF_LOW) |=> !pulse_o)
        else $error("timer output not low with pulse width off");
    a_off_high_hold: assert property ((on_code_i == ON_OFF_HIGH) |=> pulse_o)
        else $error("timer output not high with held-high code");
    a_rsvd_interval_low: assert property (
        (per_code_i == PER_RSVD && on_code_i != ON_OFF_HIGH) |=> !pulse_o)
        else $error("timer output high with reserved interval");
    a_change_restart: assert property (changed |=> cnt_reg == 15'h0)
        else $error("timer count not restarted after field change");
    a_period_wrap: assert property (
        (running && !changed && tick_i && cnt_reg == per_len - 15'd1)
        ##1 (on_code_i == $past(on_code_i) && per_code_i == $past(per_code_i))
        |-> cnt_reg == 15'h0 ##1 pulse_o)
        else $error("timer did not wrap at end of interval");

endmodule

/* rtl/switch_ctrl_pkg.sv */
package switch_ctrl_pkg;

    // clock and base tick
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_TIMER_A = 7'h0c;
    localparam logic [6:0] IDX_TIMER_B = 7'h0d;
    localparam logic [6:0] IDX_CUTOFF = 7'h10;
    localparam logic [6:0] IDX_SEL_LO = 7'h14;
    localparam logic [6:0] IDX_SEL_HI = 7'h15;
    localparam logic [6:0] IDX_DUTY_A = 7'h18;
    localparam logic [6:0] IDX_DUTY_B = 7'h19;
    localparam logic [6:0] IDX_RATE = 7'h1c;

    // field positions
    localparam int ON_LSB = 4;
    localparam int PER_LSB = 0;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 4;
    localparam int OV_DIS_BIT = 6;
    localparam int UV_DIS_BIT = 5;
    localparam int REC_BIT = 4;
    localparam int RATE_A_BIT = 0;
    localparam int RATE_B_BIT = 2;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESET_CODE = 3'h0;

    // pulse-width and interval codes
    localparam logic [2:0] ON_OFF_LOW = 3'h0;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;
    localparam logic [2:0] PER_RSVD = 3'h7;

    // on-times and periods in microseconds
    localparam int ON_T1_US = 100;
    localparam int ON_T2_US = 300;
    localparam int ON_T3_US = 1000;
    localparam int ON_T4_US = 10000;
    localparam int ON_T5_US = 20000;
    localparam int PER_T0_US = 10000;
    localparam int PER_T1_US = 20000;
    localparam int PER_T2_US = 50000;
    localparam int PER_T3_US = 100000;
    localparam int PER_T4_US = 200000;
    localparam int PER_T5_US = 1000000;
    localparam int PER_T6_US = 2000000;

    // switch selection codes
    localparam logic [2:0] SEL_OFF = 3'h0;
    localparam logic [2:0] SEL_ON = 3'h1;
    localparam logic [2:0] SEL_TIMER_A = 3'h2;
    localparam logic [2:0] SEL_TIMER_B = 3'h3;
    localparam logic [2:0] SEL_DUTY_A = 3'h4;
    localparam logic [2:0] SEL_DUTY_B = 3'h5;

    // duty generator timing
    localparam int DUTY_STEPS = 255;
    localparam int DUTY_SLOW_HZ = 200;
    localparam int DUTY_FAST_HZ = 400;
    localparam logic [11:0] STEP_SLOW_CYC = 12'(CLK_HZ / (DUTY_SLOW_HZ * DUTY_STEPS));
    localparam logic [11:0] STEP_FAST_CYC = 12'(CLK_HZ / (DUTY_FAST_HZ * DUTY_STEPS));
    localparam logic [7:0] STEP_LAST = 8'(DUTY_STEPS - 1);

    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1: on_ticks = 15'(ON_T1_US / TICK_US);
            3'h2: on_ticks = 15'(ON_T2_US / TICK_US);
            3'h3: on_ticks = 15'(ON_T3_US / TICK_US);
            3'h4: on_ticks = 15'(ON_T4_US / TICK_US);
            3'h5: on_ticks = 15'(ON_T5_US / TICK_US);
            default: on_ticks = 15'h0;
        endcase
    endfunction

    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0: per_ticks = 15'(PER_T0_US / TICK_US);
            3'h1: per_ticks = 15'(PER_T1_US / TICK_US);
            3'h2: per_ticks = 15'(PER_T2_US / TICK_US);
            3'h3: per_ticks = 15'(PER_T3_US / TICK_US);
            3'h4: per_ticks = 15'(PER_T4_US / TICK_US);
            3'h5: per_ticks = 15'(PER_T5_US / TICK_US);
            3'h6: per_ticks = 15'(PER_T6_US / TICK_US);
            default: per_ticks = 15'h0;
        endcase
    endfunction

endpackage

/* rtl/switch_timer_ctrl.sv */
// Contract
// - second timer pulse code 000 stops it low; 001-101 give 0.1-20 ms on-time.
// - pulse code 110 stops the second timer high; 111 is reserved.
// - interval codes 000-110 give 10 ms to 2 s periods; 111 reserved.
// - software assigns timer first; timer starts itself when pulse width written.
// - restart clears switch selections and also both timer fields.
// - reserved bits of timer, cutoff and switch registers read zero.
// - cutoff bit 6 low turns all switches off on supply overvoltage.
// - cutoff bit 5 low turns all switches off on supply undervoltage.
// - cutoff bit 4 high restores switches after fault; low leaves them off.
// - overcurrent or overtemperature clears that switch selection field.
// - low pair register: switch one bits 2:0, switch two bits 6:4.
// - high pair register: switch three bits 2:0, four bits 6:4.
// - timer and switch registers clear on reset, soft reset, restart.
// - first timer uses same encodings and drives timer-one switches.
// - duty value 0 off, all ones on, else value over 255.
// - duty rate select 0 gives 200 Hz, 1 gives 400 Hz.
module switch_timer_ctrl
    import switch_ctrl_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // device state
    input wire logic soft_reset_i,
    input wire logic restart_mode_i,
    // analog fault inputs
    input wire logic supply_ov_i,
    input wire logic supply_uv_i,
    input wire logic [3:0] switch_fault_i,
    // switch drive
    output logic [3:0] switch_drive_o
);

    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [2:0] ta_on_reg, ta_on_next, ta_per_reg, ta_per_next;
    logic [2:0] tb_on_reg, tb_on_next, tb_per_reg, tb_per_next;
    logic ov_dis_reg, ov_dis_next, uv_dis_reg, uv_dis_next, rec_reg, rec_next;
    logic [2:0] sel_reg [4];
    logic [2:0] sel_next [4];
    logic [7:0] duty_reg [2];
    logic [7:0] duty_next [2];
    logic rate_reg [2];
    logic rate_next [2];
    logic [3:0] drive_reg, drive_next;
    logic cut_reg;
    logic ov_meta, ov_sync, uv_meta, uv_sync;
    logic [3:0] flt_meta, flt_sync;
    logic [14:0] tick_cnt_reg, tick_cnt_next;
    logic tick;
    logic [11:0] presc_reg [2];
    logic [11:0] presc_next [2];
    logic [7:0] step_reg [2];
    logic [7:0] step_next [2];
    logic duty_out_reg [2];
    logic duty_out_next [2];
    logic timer_a, timer_b;
    logic wr;
    logic [6:0] idx;
    logic [7:0] rd_byte;
    logic cut_now;
    logic clr_all;

    // fault inputs cross in from the analog side
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ov_meta <= 1'b0;
            ov_sync <= 1'b0;
            uv_meta <= 1'b0;
            uv_sync <= 1'b0;
            flt_meta <= 4'h0;
            flt_sync <= 4'h0;
        end
        else
        begin
            ov_meta <= supply_ov_i;
            ov_sync <= ov_meta;
            uv_meta <= supply_uv_i;
            uv_sync <= uv_meta;
            flt_meta <= switch_fault_i;
            flt_sync <= flt_meta;
        end
    end

    assign cut_now = (ov_sync && !ov_dis_reg) || (uv_sync && !uv_dis_reg);
    assign clr_all = soft_reset_i || restart_mode_i;
    assign idx = wb_adr_i[8:2];

    // register file and bus
    always_comb
    begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        wr = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
        // reserved bits read zero, field layout
        case (idx)
            IDX_TIMER_A: rd_byte = {1'b0, ta_on_reg, 1'b0, ta_per_reg};
            IDX_TIMER_B: rd_byte = {1'b0, tb_on_reg, 1'b0, tb_per_reg};
            IDX_CUTOFF: rd_byte = {1'b0, ov_dis_reg, uv_dis_reg, rec_reg, 4'h0};
            IDX_SEL_LO: rd_byte = {1'b0, sel_reg[1], 1'b0, sel_reg[0]};
            IDX_SEL_HI: rd_byte = {1'b0, sel_reg[3], 1'b0, sel_reg[2]};
            IDX_DUTY_A: rd_byte = duty_reg[0];
            IDX_DUTY_B: rd_byte = duty_reg[1];
            IDX_RATE: rd_byte = {5'h0, rate_reg[1], 1'b0, rate_reg[0]};
            default: rd_byte = 8'h00;
        endcase
        dat_next = ack_next ? {24'h0, rd_byte} : 32'h0;
        ta_on_next = ta_on_reg;
        ta_per_next = ta_per_reg;
        tb_on_next = tb_on_reg;
        tb_per_next = tb_per_reg;
        ov_dis_next = ov_dis_reg;
        uv_dis_next = uv_dis_reg;
        rec_next = rec_reg;
        sel_next = sel_reg;
        duty_next = duty_reg;
        rate_next = rate_reg;
        if (wr)
        begin
            case (idx)
                IDX_TIMER_A:
                begin
                    ta_on_next = wb_dat_i[ON_LSB +: 3];
                    ta_per_next = wb_dat_i[PER_LSB +: 3];
                end
                IDX_TIMER_B:
                begin
                    tb_on_next = wb_dat_i[ON_LSB +: 3];
                    tb_per_next = wb_dat_i[PER_LSB +: 3];
                end
                IDX_CUTOFF:
                begin
                    ov_dis_next = wb_dat_i[OV_DIS_BIT];
                    uv_dis_next = wb_dat_i[UV_DIS_BIT];
                    rec_next = wb_dat_i[REC_BIT];
                end
                IDX_SEL_LO:
                begin
                    sel_next[0] = wb_dat_i[SEL_LO_LSB +: 3];
                    sel_next[1] = wb_dat_i[SEL_HI_LSB +: 3];
                end
                IDX_SEL_HI:
                begin
                    sel_next[2] = wb_dat_i[SEL_LO_LSB +: 3];
                    sel_next[3] = wb_dat_i[SEL_HI_LSB +: 3];
                end
                IDX_DUTY_A: duty_next[0] = wb_dat_i[7:0];
                IDX_DUTY_B: duty_next[1] = wb_dat_i[7:0];
                IDX_RATE:
                begin
                    rate_next[0] = wb_dat_i[RATE_A_BIT];
                    rate_next[1] = wb_dat_i[RATE_B_BIT];
                end
                default:
                begin
                end
            endcase
        end
        // hardware clear beats a software write
        for (int i = 0; i < 4; i++)
        begin
            if (flt_sync[i])
            begin
                sel_next[i] = RESET_CODE;
            end
        end
        // without recovery the switches stay off
        if (cut_reg && !cut_now && !rec_reg)
        begin
            for (int i = 0; i < 4; i++)
            begin
                sel_next[i] = RESET_CODE;
            end
        end
        // restart clears selections and both timer fields
        if (clr_all)
        begin
            for (int i = 0; i < 4; i++)
            begin
                sel_next[i] = RESET_CODE;
            end
            ta_on_next = RESET_CODE;
            ta_per_next = RESET_CODE;
            tb_on_next = RESET_CODE;
            tb_per_next = RESET_CODE;
        end
        if (soft_reset_i)
        begin
            ov_dis_next = 1'b0;
            uv_dis_next = 1'b0;
            rec_next = 1'b0;
            duty_next[0] = RESET_BYTE;
            duty_next[1] = RESET_BYTE;
            rate_next[0] = 1'b0;
            rate_next[1] = 1'b0;
        end
    end

    // tick divider and duty generators
    always_comb
    begin
        tick = (tick_cnt_reg == 15'(TICK_LEN - 1));
        tick_cnt_next = tick ? 15'h0 : tick_cnt_reg + 15'd1;
        for (int g = 0; g < 2; g++)
        begin
            presc_next[g] = presc_reg[g] + 12'd1;
            step_next[g] = step_reg[g];
            // rate select picks the step length
            if (presc_reg[g] >= (rate_reg[g] ? STEP_FAST_CYC : STEP_SLOW_CYC) - 12'd1)
            begin
                presc_next[g] = 12'h0;
                step_next[g] = (step_reg[g] >= STEP_LAST) ? 8'h0 : step_reg[g] + 8'd1;
            end
            // on for duty steps out of 255
            duty_out_next[g] = (duty_reg[g] == 8'hff) || (step_next[g] < duty_reg[g]);
        end
    end

    // switch drive selection
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            // off, on, timers; duty sources; reserved off
            case (sel_reg[i])
                SEL_OFF: drive_next[i] = 1'b0;
                SEL_ON: drive_next[i] = 1'b1;
                SEL_TIMER_A: drive_next[i] = timer_a;
                SEL_TIMER_B: drive_next[i] = timer_b;
                SEL_DUTY_A: drive_next[i] = duty_out_reg[0];
                SEL_DUTY_B: drive_next[i] = duty_out_reg[1];
                default: drive_next[i] = 1'b0;
            endcase
        end
        if (cut_now)
        begin
            drive_next = 4'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            ta_on_reg <= RESET_CODE;
            ta_per_reg <= RESET_CODE;
            tb_on_reg <= RESET_CODE;
            tb_per_reg <= RESET_CODE;
            ov_dis_reg <= 1'b0;
            uv_dis_reg <= 1'b0;
            rec_reg <= 1'b0;
            sel_reg <= '{default: RESET_CODE};
            duty_reg <= '{default: RESET_BYTE};
            rate_reg <= '{default: 1'b0};
            drive_reg <= 4'h0;
            cut_reg <= 1'b0;
            tick_cnt_reg <= 15'h0;
            presc_reg <= '{default: 12'h0};
            step_reg <= '{default: 8'h0};
            duty_out_reg <= '{default: 1'b0};
        end
        else
        begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            ta_on_reg <= ta_on_next;
            ta_per_reg <= ta_per_next;
            tb_on_reg <= tb_on_next;
            tb_per_reg <= tb_per_next;
            ov_dis_reg <= ov_dis_next;
            uv_dis_reg <= uv_dis_next;
            rec_reg <= rec_next;
            sel_reg <= sel_next;
            duty_reg <= duty_next;
            rate_reg <= rate_next;
            drive_reg <= drive_next;
            cut_reg <= cut_now;
            tick_cnt_reg <= tick_cnt_next;
            presc_reg <= presc_next;
            step_reg <= step_next;
            duty_out_reg <= duty_out_next;
        end
    end

    interval_gen u_gen_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .on_code_i(ta_on_reg),
        .per_code_i(ta_per_reg),
        .pulse_o(timer_a)
    );

    interval_gen u_gen_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .on_code_i(tb_on_reg),
        .per_code_i(tb_per_reg),
        .pulse_o(timer_b)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign switch_drive_o = drive_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ov_all_off: assert property ((ov_sync && !ov_dis_reg) |=> switch_drive_o == 4'h0)
        else $error("switch on during enabled overvoltage cutoff");
    a_uv_all_off: assert property ((uv_sync && !uv_dis_reg) |=> switch_drive_o == 4'h0)
        else $error("switch on during enabled undervoltage cutoff");
    a_no_recovery_clear: assert property (
        (cut_reg && !cut_now && !rec_reg) |=> sel_reg[0] == 3'h0 && sel_reg[3] == 3'h0)
        else $error("selection kept after fault without recovery");
    a_fault_clears_sel: assert property (
        flt_sync[2] |=> sel_reg[2] == 3'h0 ##1 (sel_reg[2] == 3'h0 || $past(wr)))
        else $error("selection not cleared after switch fault");
    a_restart_clears: assert property (
        restart_mode_i |=> {tb_on_reg, tb_per_reg, sel_reg[1]} == 9'h0)
        else $error("registers not cleared in restart mode");
    a_rsvd_reads_zero: assert property (
        (ack_next && (idx == IDX_SEL_LO || idx == IDX_TIMER_B))
        |=> wb_ack_o && wb_dat_o[7] == 1'b0 && wb_dat_o[3] == 1'b0)
        else $error("reserved bit read as one");
    a_on_select_drives: assert property (
        (sel_reg[0] == SEL_ON && !cut_now) |=> switch_drive_o[0])
        else $error("switch one not driven with on selection");
    a_duty_zero_off: assert property (
        (duty_reg[1] == 8'h00) [*2] |=> !duty_out_reg[1])
        else $error("duty output high with zero duty value");
    a_rsvd_sel_off: assert property (
        (sel_reg[3] == 3'h6 || sel_reg[3] == 3'h7) |=> !switch_drive_o[3])
        else $error("switch four driven with reserved selection");

endmodule
